// *** logic/cmd_consts.vh ***
// constants for the vicinity tag custom command handler
`ifndef CMD_CONSTS_VH
`define CMD_CONSTS_VH
// command codes
`define CMD_ARM 8'hD2
`define CMD_QARM 8'hC2
`define CMD_BURST 8'hC3
`define CMD_INV 8'hD1
// request flag bit positions
`define RF_SUBC 0
`define RF_RATE 1
`define RF_INV 2
`define RF_EXT 3
`define RF_SEL 4
`define RF_ADDR 5
`define RF_AFI 4
`define RF_NBS 5
`define RF_OPT 6
// response flags and error codes
`define RESP_OK 8'h00
`define RESP_FAIL 8'h01
`define ERR_OTHER 8'h0F
`define ERR_ADDR 8'h10
// frame crc
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'h8408
`define CRC_RESIDUE 16'hF0B8
// request layout, in bytes
`define BUF_LEN 5'h10
`define HDR_LEN 5'h03
`define UID_LEN 5'h08
`define CRC_LEN 5'h02
`define BURST_ARGS 5'h03
`define ID_LAST 4'h8
// burst and inventory limits
`define BLK_MAX 16'h07FF
`define SECT_SPAN 9'h01F
`define MASK_MAX 8'h40
`define MASK_MAX16 8'h3C
`define SLOT_LAST 4'hF
// register byte addresses and reset values
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_UID_LO 8'h08
`define REG_UID_HI 8'h0C
`define REG_ID 8'h10
`define CTRL_RST 32'h0000_0001
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** logic/crc16_byte.v ***
// one-byte step of the reflected frame crc16
`include "cmd_consts.vh"
module crc16_byte (
	// running value and byte
	input wire [15:0] crc_in,
	input wire [7:0] data,
	// updated value
	output wire [15:0] crc_out
);
	wire [15:0] stage [0:8];
	assign stage[0] = crc_in ^ {8'h00, data};
	genvar b;
	generate
		for (b = 0; b < 8; b = b + 1) begin : step
			assign stage[b + 1] = stage[b][0] ?
				((stage[b] >> 1) ^ `CRC_POLY) : (stage[b] >> 1);
		end
	endgenerate
	assign crc_out = stage[8];
endmodule

// *** logic/tag_cmd_handler.v ***
// custom command handler: arm, quick arm, armed inventory, burst read
`include "cmd_consts.vh"
module tag_cmd_handler #(
	parameter [7:0] MFG_CODE = 8'h5A, // arbitrary maker code
	parameter AW = 8
) (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// register bus
	input wire [AW-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [AW-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	// request link from the demodulator
	input wire rf_clk,
	input wire rf_bit,
	input wire rf_frame,
	// response byte stream to the modulator
	output wire tx_valid,
	input wire tx_ready,
	output wire [7:0] tx_data,
	output wire tx_first,
	output wire tx_last,
	output wire tx_fast,
	output wire tx_high_rate,
	output wire tx_dual_subc,
	// block memory and sector security, asynchronous read
	output wire [10:0] mem_addr,
	input wire [31:0] mem_rdata,
	input wire [4:0] sec_status,
	// tag state
	input wire tag_ready,
	input wire power_off
);
	localparam [4:0] S_IDLE = 5'b00001, S_RX = 5'b00010, S_EXEC = 5'b00100,
		S_LOAD = 5'b01000, S_SEND = 5'b10000;
	localparam [1:0] K_ID = 2'd0, K_ERR = 2'd1, K_DATA = 2'd2;
	localparam [1:0] PH_FLAGS = 2'd0, PH_BODY = 2'd1, PH_CRC0 = 2'd2,
		PH_CRC1 = 2'd3;
	integer i;
	integer j;
	// pin synchronisers and edge finders
	reg [1:0] clk_sy_ff, bit_sy_ff, frm_sy_ff;
	reg clk_d_ff, frm_d_ff;
	always @(posedge aclk) begin
		if (!aresetn) begin
			clk_sy_ff <= 2'b00;
			bit_sy_ff <= 2'b00;
			frm_sy_ff <= 2'b00;
			clk_d_ff <= 1'b0;
			frm_d_ff <= 1'b0;
		end else begin
			clk_sy_ff <= {clk_sy_ff[0], rf_clk};
			bit_sy_ff <= {bit_sy_ff[0], rf_bit};
			frm_sy_ff <= {frm_sy_ff[0], rf_frame};
			clk_d_ff <= clk_sy_ff[1];
			frm_d_ff <= frm_sy_ff[1];
		end
	end
	wire clk_rise = clk_sy_ff[1] & ~clk_d_ff;
	wire frm_rise = frm_sy_ff[1] & ~frm_d_ff;
	wire frm_fall = ~frm_sy_ff[1] & frm_d_ff;
	// state
	reg [4:0] st_ff;
	reg [7:0] sh_ff;
	reg [2:0] bitc_ff;
	reg [4:0] nbytes_ff;
	reg ovf_ff;
	reg [15:0] crc_rx_ff, crc_tx_ff;
	reg [7:0] buf_ff [0:15];
	reg latch_ff, inv_act_ff;
	reg [3:0] slot_ff, my_slot_ff;
	reg [1:0] kind_ff, ph_ff;
	reg [7:0] err_ff, last_err_ff, tx_data_ff, rflags_ff;
	reg [3:0] pos_ff;
	reg [2:0] sub_ff;
	reg [4:0] left_ff;
	reg [10:0] mem_addr_ff;
	reg fast_ff, first_ff, last_ff;
	reg [31:0] ctrl_ff;
	reg [63:0] uid_ff;
	reg [7:0] dsfid_ff, afi_ff;
	wire [7:0] rx_byte = {bit_sy_ff[1], sh_ff[7:1]};
	wire [15:0] crc_rx_nxt, crc_tx_nxt;
	reg [7:0] ld_byte;
	crc16_byte u_crc_rx (.crc_in(crc_rx_ff), .data(rx_byte),
		.crc_out(crc_rx_nxt));
	crc16_byte u_crc_tx (.crc_in(crc_tx_ff), .data(ld_byte),
		.crc_out(crc_tx_nxt));
	// request decode
	wire [7:0] rq_flags = buf_ff[0];
	wire ours = ctrl_ff[0] && nbytes_ff >= `HDR_LEN && !ovf_ff &&
		bitc_ff == 3'h0 && buf_ff[2] == MFG_CODE;
	wire crc_ok = (crc_rx_ff == `CRC_RESIDUE);
	wire addressed = rq_flags[`RF_ADDR];
	wire [4:0] off = addressed ? (`HDR_LEN + `UID_LEN) : `HDR_LEN;
	wire [15:0] first_blk = {buf_ff[off[3:0] + 4'h1], buf_ff[off[3:0]]};
	wire [7:0] blk_cnt = buf_ff[off[3:0] + 4'h2];
	wire [8:0] span = {4'h0, first_blk[4:0]} + {1'b0, blk_cnt};
	wire [4:0] mpos = `HDR_LEN + {4'h0, rq_flags[`RF_AFI]};
	wire [7:0] mlen = buf_ff[mpos[3:0]];
	wire [8:0] mround = {1'b0, mlen} + 9'h007;
	wire [4:0] mbytes = {1'b0, mround[6:3]};
	wire one_slot = rq_flags[`RF_NBS];
	reg uid_ok;
	reg [63:0] mask_v;
	reg [4:0] midx;
	always @* begin
		uid_ok = 1'b1;
		mask_v = 64'h0;
		midx = 5'h00;
		for (i = 0; i < 8; i = i + 1) begin
			if (buf_ff[3 + i] != uid_ff[8 * i +: 8])
				uid_ok = 1'b0;
			midx = mpos + 5'h01 + i[4:0];
			if (i[4:0] < mbytes)
				mask_v[8 * i +: 8] = buf_ff[midx[3:0]];
		end
	end
	wire [63:0] low_mask = ~({64{1'b1}} << mlen);
	wire mask_hit = ((uid_ff ^ mask_v) & low_mask) == 64'h0;
	wire [63:0] uid_sh = uid_ff >> mlen;
	wire afi_ok = !rq_flags[`RF_AFI] || buf_ff[3] == 8'h00 ||
		buf_ff[3] == afi_ff;
	wire inv_fmt = rq_flags[`RF_INV] &&
		nbytes_ff == mpos + 5'h01 + mbytes + `CRC_LEN &&
		mlen <= (one_slot ? `MASK_MAX : `MASK_MAX16);
	wire empty_frm = nbytes_ff == 5'h00 && bitc_ff == 3'h0;
	reg p_reply, p_latch, p_fast, p_inv;
	reg [1:0] p_kind;
	reg [7:0] p_err;
	always @* begin
		p_reply = 1'b0;
		p_latch = 1'b0;
		p_fast = 1'b0;
		p_inv = 1'b0;
		p_kind = K_ID;
		p_err = `ERR_OTHER;
		if (ours) begin
			case (buf_ff[1])
			`CMD_ARM, `CMD_QARM: begin
				// errors and addressed use give silence
				if (crc_ok && nbytes_ff == `HDR_LEN + `CRC_LEN &&
					!rq_flags[`RF_SEL] && !addressed &&
					tag_ready) begin
					p_reply = 1'b1;
					p_latch = 1'b1;
					p_fast = (buf_ff[1] == `CMD_QARM);
				end
			end
			`CMD_BURST: begin
				if (!rq_flags[`RF_INV] && (!addressed || uid_ok)) begin
					p_reply = 1'b1;
					p_fast = 1'b1;
					p_kind = K_ERR;
					if (!crc_ok || !rq_flags[`RF_EXT] ||
						nbytes_ff != off + `BURST_ARGS + `CRC_LEN)
						p_err = `ERR_OTHER;
					else if (first_blk > `BLK_MAX ||
						span > `SECT_SPAN)
						p_err = `ERR_ADDR;
					else
						p_kind = K_DATA;
				end
			end
			`CMD_INV: begin
				if (latch_ff && crc_ok && inv_fmt &&
					afi_ok && mask_hit) begin
					p_inv = 1'b1;
					p_reply = one_slot || uid_sh[3:0] == 4'h0;
				end
			end
			default: p_reply = 1'b0;
			endcase
		end
	end
	// response byte selection
	wire [2:0] sub_lim = rflags_ff[`RF_OPT] ? 3'h4 : 3'h3;
	wire [2:0] dsel = sub_ff - {2'b00, rflags_ff[`RF_OPT]};
	always @* begin
		ld_byte = (kind_ff == K_ERR) ? `RESP_FAIL : `RESP_OK;
		case (ph_ff)
		PH_BODY:
			if (kind_ff == K_ERR)
				ld_byte = err_ff;
			else if (kind_ff == K_ID)
				ld_byte = (pos_ff == 4'h0) ? dsfid_ff :
					uid_ff[8 * (pos_ff - 4'h1) +: 8];
			else if (rflags_ff[`RF_OPT] && sub_ff == 3'h0)
				ld_byte = {3'b000, sec_status};
			else
				ld_byte = mem_rdata[8 * dsel[1:0] +: 8];
		PH_CRC0: ld_byte = ~crc_tx_ff[7:0];
		PH_CRC1: ld_byte = ~crc_tx_ff[15:8];
		default: ld_byte = (kind_ff == K_ERR) ? `RESP_FAIL : `RESP_OK;
		endcase
	end
	wire tx_go = (st_ff == S_SEND) && tx_ready;
	always @(posedge aclk) begin
		if (st_ff == S_RX && clk_rise && frm_sy_ff[1] && bitc_ff == 3'h7 &&
			nbytes_ff < `BUF_LEN)
			buf_ff[nbytes_ff[3:0]] <= rx_byte;
	end
	always @(posedge aclk) begin
		if (!aresetn || power_off) begin
			latch_ff <= 1'b0;
		end else if (st_ff == S_EXEC && p_latch) begin
			latch_ff <= 1'b1;
		end
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= S_IDLE;
			sh_ff <= 8'h00;
			bitc_ff <= 3'h0;
			nbytes_ff <= 5'h00;
			ovf_ff <= 1'b0;
			crc_rx_ff <= `CRC_INIT;
			crc_tx_ff <= `CRC_INIT;
			inv_act_ff <= 1'b0;
			slot_ff <= 4'h0;
			my_slot_ff <= 4'h0;
			kind_ff <= K_ID;
			ph_ff <= PH_FLAGS;
			err_ff <= 8'h00;
			last_err_ff <= 8'h00;
			tx_data_ff <= 8'h00;
			rflags_ff <= 8'h00;
			pos_ff <= 4'h0;
			sub_ff <= 3'h0;
			left_ff <= 5'h00;
			mem_addr_ff <= 11'h000;
			fast_ff <= 1'b0;
			first_ff <= 1'b0;
			last_ff <= 1'b0;
		end else begin
			case (st_ff)
			S_IDLE: if (frm_rise) begin
				st_ff <= S_RX;
				bitc_ff <= 3'h0;
				nbytes_ff <= 5'h00;
				ovf_ff <= 1'b0;
				crc_rx_ff <= `CRC_INIT;
			end
			S_RX: begin
				if (frm_fall) begin
					st_ff <= S_EXEC;
				end else if (clk_rise) begin
					sh_ff <= rx_byte;
					bitc_ff <= bitc_ff + 3'h1;
					if (bitc_ff == 3'h7) begin
						if (nbytes_ff == `BUF_LEN)
							ovf_ff <= 1'b1;
						else
							nbytes_ff <= nbytes_ff + 5'h01;
						crc_rx_ff <= crc_rx_nxt;
					end
				end
			end
			S_EXEC: begin
				st_ff <= p_reply ? S_LOAD : S_IDLE;
				kind_ff <= p_kind;
				err_ff <= p_err;
				fast_ff <= p_fast;
				rflags_ff <= rq_flags;
				ph_ff <= PH_FLAGS;
				pos_ff <= 4'h0;
				sub_ff <= 3'h0;
				left_ff <= blk_cnt[4:0];
				mem_addr_ff <= first_blk[10:0];
				crc_tx_ff <= `CRC_INIT;
				first_ff <= 1'b1;
				if (p_kind == K_ERR && p_reply)
					last_err_ff <= p_err;
				if (p_inv) begin
					// one-slot mode ends at once
					inv_act_ff <= !one_slot;
					slot_ff <= 4'h0;
					my_slot_ff <= uid_sh[3:0];
				end else if (inv_act_ff && empty_frm) begin
					// reader closed the slot with a bare end of frame
					slot_ff <= slot_ff + 4'h1;
					inv_act_ff <= (slot_ff + 4'h1) != `SLOT_LAST;
					if ((slot_ff + 4'h1) == my_slot_ff) begin
						st_ff <= S_LOAD;
						kind_ff <= K_ID;
						fast_ff <= 1'b0;
					end
				end else begin
					inv_act_ff <= 1'b0;
				end
			end
			S_LOAD: begin
				tx_data_ff <= ld_byte;
				last_ff <= (ph_ff == PH_CRC1);
				if (ph_ff == PH_FLAGS || ph_ff == PH_BODY)
					crc_tx_ff <= crc_tx_nxt;
				st_ff <= S_SEND;
			end
			S_SEND: if (tx_go) begin
				first_ff <= 1'b0;
				st_ff <= S_LOAD;
				case (ph_ff)
				PH_FLAGS: ph_ff <= PH_BODY;
				PH_BODY:
					if (kind_ff == K_ERR ||
						(kind_ff == K_ID && pos_ff == `ID_LAST)) begin
						ph_ff <= PH_CRC0;
					end else if (kind_ff == K_ID) begin
						pos_ff <= pos_ff + 4'h1;
					end else if (sub_ff != sub_lim) begin
						sub_ff <= sub_ff + 3'h1;
					end else if (left_ff == 5'h00) begin
						ph_ff <= PH_CRC0;
					end else begin
						sub_ff <= 3'h0;
						left_ff <= left_ff - 5'h01;
						mem_addr_ff <= mem_addr_ff + 11'h001;
					end
				PH_CRC0: ph_ff <= PH_CRC1;
				default: st_ff <= S_IDLE;
				endcase
			end
			default: st_ff <= S_IDLE;
			endcase
		end
	end
	assign tx_valid = (st_ff == S_SEND);
	assign tx_data = tx_data_ff;
	assign tx_first = first_ff;
	assign tx_last = last_ff;
	assign tx_fast = fast_ff;
	assign tx_high_rate = rflags_ff[`RF_RATE];
	assign tx_dual_subc = rflags_ff[`RF_SUBC];
	assign mem_addr = mem_addr_ff;
	// register bus slave; address and data are taken together
	reg bvalid_ff, rvalid_ff;
	reg [1:0] bresp_ff, rresp_ff;
	reg [31:0] rdata_ff, wr_word, rd_word;
	reg wr_hit, rd_hit;
	wire wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_ff;
	wire rd_go = s_axi_arvalid & ~rvalid_ff;
	wire [31:0] status_w = {16'h0000, last_err_ff, 5'h00, inv_act_ff,
		(st_ff != S_IDLE), latch_ff};
	always @* begin
		wr_hit = 1'b1;
		case (s_axi_awaddr[7:0])
		`REG_CTRL: wr_word = ctrl_ff;
		`REG_UID_LO: wr_word = uid_ff[31:0];
		`REG_UID_HI: wr_word = uid_ff[63:32];
		`REG_ID: wr_word = {16'h0000, afi_ff, dsfid_ff};
		default: begin
			wr_word = 32'h0000_0000;
			wr_hit = 1'b0;
		end
		endcase
		for (j = 0; j < 4; j = j + 1)
			if (s_axi_wstrb[j])
				wr_word[8 * j +: 8] = s_axi_wdata[8 * j +: 8];
		rd_hit = 1'b1;
		case (s_axi_araddr[7:0])
		`REG_CTRL: rd_word = ctrl_ff;
		`REG_STATUS: rd_word = status_w;
		`REG_UID_LO: rd_word = uid_ff[31:0];
		`REG_UID_HI: rd_word = uid_ff[63:32];
		`REG_ID: rd_word = {16'h0000, afi_ff, dsfid_ff};
		default: begin
			rd_word = 32'h0000_0000;
			rd_hit = 1'b0;
		end
		endcase
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff <= `CTRL_RST;
			uid_ff <= 64'h0;
			dsfid_ff <= 8'h00;
			afi_ff <= 8'h00;
			bvalid_ff <= 1'b0;
			bresp_ff <= `RESP_OKAY;
			rvalid_ff <= 1'b0;
			rresp_ff <= `RESP_OKAY;
			rdata_ff <= 32'h0000_0000;
		end else begin
			if (wr_go) begin
				bvalid_ff <= 1'b1;
				bresp_ff <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
				case (s_axi_awaddr[7:0])
				`REG_CTRL: ctrl_ff <= {31'h0, wr_word[0]};
				`REG_UID_LO: uid_ff[31:0] <= wr_word;
				`REG_UID_HI: uid_ff[63:32] <= wr_word;
				`REG_ID: {afi_ff, dsfid_ff} <= wr_word[15:0];
				default: bresp_ff <= `RESP_SLVERR;
				endcase
			end else if (s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
			if (rd_go) begin
				rvalid_ff <= 1'b1;
				rdata_ff <= rd_word;
				rresp_ff <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rready) begin
				rvalid_ff <= 1'b0;
			end
		end
	end
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = ~rvalid_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
endmodule

// *** testbench/tag_cmd_monitor.sv ***
// port assertions for the tag command handler
module tag_cmd_monitor (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// register bus
	input wire s_axi_awvalid,
	input wire s_axi_wvalid,
	input wire s_axi_awready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	// response stream
	input wire tx_valid,
	input wire tx_ready,
	input wire [7:0] tx_data,
	input wire tx_first,
	input wire tx_last,
	input wire tx_fast
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_take;
		tx_valid && tx_ready;
	endsequence
	sequence s_last;
		tx_valid && tx_ready && tx_last;
	endsequence
	a_reset_quiet: assert property ($rose(aresetn) |->
		!tx_valid && !s_axi_bvalid && !s_axi_rvalid)
		else $error("outputs busy right after reset");
	a_bvalid_next: assert property (s_axi_awvalid && s_axi_wvalid &&
		s_axi_awready |=> s_axi_bvalid)
		else $error("write response late");
	a_rvalid_next: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid)
		else $error("read response late");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_tx_hold: assert property (tx_valid && !tx_ready |=>
		tx_valid && $stable(tx_data))
		else $error("response byte changed before taken");
	a_load_gap: assert property (s_take ##0 !tx_last |=> !tx_valid)
		else $error("no load cycle between bytes");
	a_frame_gap: assert property (s_last |=> !tx_valid [*4])
		else $error("new response without a request");
	a_first_flags: assert property (tx_valid && tx_first |->
		tx_data[7:1] == 7'h00)
		else $error("bad response flags byte");
	a_error_fast: assert property (tx_valid && tx_first &&
		tx_data == 8'h01 |-> tx_fast)
		else $error("burst error answer not at double rate");
	a_fast_steady: assert property (s_take ##0 !tx_last |=> $stable(tx_fast))
		else $error("rate changed inside a response");
endmodule
bind tag_cmd_handler tag_cmd_monitor i_mon (.aclk, .aresetn,
	.s_axi_awvalid, .s_axi_wvalid, .s_axi_awready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .tx_valid, .tx_ready,
	.tx_data, .tx_first, .tx_last, .tx_fast);

// *** testbench/vcd_reader.sv ***
// reader model: frames requests onto the link pins
module vcd_reader (
	// link pins
	output logic rf_clk,
	output logic rf_bit,
	output logic rf_frame
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		rf_clk = 0;
		rf_bit = 0;
		rf_frame = 0;
	end
	function automatic logic [15:0] crc16(input logic [7:0] b[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (b[i]) begin
			c ^= {8'h00, b[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
		end
		return ~c;
	endfunction
	// clock only runs inside a frame; bad flips crc bit 0
	task automatic send(input logic [7:0] b[$], input logic bad);
		logic [15:0] c;
		c = crc16(b) ^ {15'h0, bad};
		b.push_back(c[7:0]);
		b.push_back(c[15:8]);
		rf_frame = 1;
		#400;
		foreach (b[i]) for (int j = 0; j < 8; j++) begin
			rf_bit = b[i][j];
			#62.5 rf_clk = 1;
			#62.5 rf_clk = 0;
		end
		#100 rf_frame = 0;
		rf_bit = ~rf_bit;
	endtask
	// carrier period in ns, kept short so empty slots stay cheap
	parameter real CARRIER_NS = 1.0;
	// bare end of frame closes an empty inventory slot
	task automatic bare_eof();
		#(4384 * CARRIER_NS);
		rf_frame = 1;
		#400 rf_frame = 0;
	endtask
endmodule

// *** testbench/tag_cmd_handler_tb_top.sv ***
// bench top for the tag command handler
`include "cmd_consts.vh"
module tag_cmd_handler_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] MFG = 8'h5A; // arbitrary maker code
	logic aclk = 0, aresetn = 0, tx_ready = 0, tag_ready = 0, power_off = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire s_axi_rvalid, rf_clk, rf_bit, rf_frame, tx_valid, tx_first;
	wire tx_last, tx_fast, tx_high_rate, tx_dual_subc;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata, mem_rdata;
	wire [7:0] tx_data;
	wire [10:0] mem_addr;
	wire [4:0] sec_status;
	logic [7:0] q[$], e[$], dsfid;
	logic [63:0] uid;
	int n_errors = 0, tests_run = 0;
	logic [7:0] acode[2] = '{`CMD_ARM, `CMD_QARM};
	// error table: sector cross, no ext bit, block past end, bad crc
	logic [15:0] ef[4] = '{16'h001F, 16'h0010, 16'h0800, 16'h0005};
	logic [7:0] en[4] = '{8'h01, 8'h00, 8'h00, 8'h00};
	logic [7:0] efl[4] = '{8'h08, 8'h00, 8'h08, 8'h08};
	logic ebad[4] = '{1'b0, 1'b0, 1'b0, 1'b1};
	logic [7:0] ecode[4] = '{`ERR_ADDR, `ERR_OTHER, `ERR_ADDR, `ERR_OTHER};
	function automatic logic [31:0] dat_of(input logic [10:0] a);
		return {a[7:0] ^ 8'hA5, 5'h00, a, 8'h3C};
	endfunction
	function automatic logic [4:0] sec_of(input logic [10:0] a);
		return a[9:5] ^ 5'h0B;
	endfunction
	assign mem_rdata = dat_of(mem_addr);
	assign sec_status = sec_of(mem_addr);
	tag_cmd_handler #(.MFG_CODE(MFG), .AW(8)) i_dut (.aclk, .aresetn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .rf_clk, .rf_bit, .rf_frame, .tx_valid, .tx_ready,
		.tx_data, .tx_first, .tx_last, .tx_fast, .tx_high_rate,
		.tx_dual_subc, .mem_addr, .mem_rdata, .sec_status, .tag_ready,
		.power_off);
	vcd_reader i_vcd (.rf_clk, .rf_bit, .rf_frame);
	always #5 aclk = ~aclk;
	// modulator stalls about one cycle in four
	always @(posedge aclk) tx_ready <= ($urandom % 4) != 0;
	task automatic chk_word(string n, logic [31:0] x, logic [31:0] g);
		tests_run++;
		if (g !== x) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic chk_bit(string n, logic x, logic g);
		chk_word(n, {31'h0, x}, {31'h0, g});
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int k;
		logic aw_ok, w_ok;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		k = 0;
		aw_ok = 0;
		w_ok = 0;
		// each channel is released at its own ready
		while (!(aw_ok && w_ok) && k < 50) begin
			@(posedge aclk);
			k++;
			if (!aw_ok && s_axi_awready === 1) begin
				aw_ok = 1;
				s_axi_awvalid <= 0;
			end
			if (!w_ok && s_axi_wready === 1) begin
				w_ok = 1;
				s_axi_wvalid <= 0;
			end
		end
		while (s_axi_bvalid !== 1 && k < 50) begin
			@(posedge aclk);
			k++;
		end
		r = s_axi_bresp;
		s_axi_bready <= 0;
		chk_bit("write answered", 1, k < 50);
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int k;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		k = 0;
		do begin
			@(posedge aclk);
			k++;
		end while (s_axi_arready !== 1 && k < 50);
		s_axi_arvalid <= 0;
		while (s_axi_rvalid !== 1 && k < 50) begin
			@(posedge aclk);
			k++;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 0;
		chk_bit("read answered", 1, k < 50);
	endtask
	task automatic send3(input logic [7:0] f, c, input logic bad);
		q = {f, c, MFG};
		i_vcd.send(q, bad);
	endtask
	task automatic expect_silent(string n);
		int k;
		k = 0;
		repeat (60) begin
			@(posedge aclk);
			if (tx_valid !== 1'b0) k++;
		end
		chk_word(n, 0, k);
	endtask
	task automatic expect_resp(input logic fast, string n);
		logic [15:0] c;
		int i, k;
		c = i_vcd.crc16(e);
		e.push_back(c[7:0]);
		e.push_back(c[15:8]);
		i = 0;
		k = 0;
		while (i < e.size() && k < 3000) begin
			@(posedge aclk);
			k++;
			if (tx_valid === 1 && tx_ready === 1) begin
				chk_word(n, e[i], tx_data);
				if (i == 0) chk_bit("tx_fast", fast, tx_fast);
				if (i == 0)
					chk_word("rate flags", q[0][1:0],
						{tx_high_rate, tx_dual_subc});
				chk_bit("tx_first", i == 0, tx_first);
				chk_bit("tx_last", i == e.size() - 1, tx_last);
				i++;
			end
		end
		chk_word("response length", e.size(), i);
	endtask
	function automatic void id_resp();
		e = {8'h00, dsfid};
		for (int i = 0; i < 8; i++) e.push_back(uid[8*i+:8]);
	endfunction
	task automatic burst(input logic [15:0] fb, input logic [7:0] nb,
		input logic opt);
		logic [31:0] w;
		q = {8'h08 | (8'(opt) << `RF_OPT), `CMD_BURST, MFG, fb[7:0],
			fb[15:8], nb};
		i_vcd.send(q, 0);
		e = {`RESP_OK};
		for (int b = fb; b <= fb + nb; b++) begin
			w = dat_of(11'(b));
			if (opt) e.push_back({3'h0, sec_of(11'(b))});
			for (int i = 0; i < 4; i++) e.push_back(w[8*i+:8]);
		end
		expect_resp(1, "burst data");
	endtask
	initial begin
		#900000;
		n_errors++;
		tally_and_finish();
	end
	initial begin
		logic [31:0] w;
		logic [1:0] r;
		logic [10:0] fb;
		void'($urandom(12));
		repeat (10) @(posedge aclk);
		aresetn <= 1;
		repeat (3) @(posedge aclk);
		axr(`REG_CTRL, w, r);
		chk_word("ctrl reset", `CTRL_RST, w);
		axr(`REG_STATUS, w, r);
		chk_bit("latch at power-on", 0, w[0]);
		axr(8'h14, w, r);
		chk_word("unmapped rresp", `RESP_SLVERR, r);
		axw(8'h14, 32'hFFFF_FFFF, r);
		chk_word("unmapped bresp", `RESP_SLVERR, r);
		uid = {$urandom, $urandom};
		dsfid = 8'($urandom);
		axw(`REG_UID_LO, uid[31:0], r);
		axw(`REG_UID_HI, uid[63:32], r);
		axw(`REG_ID, {24'h0, dsfid}, r);
		axr(`REG_UID_HI, w, r);
		chk_word("uid high word", uid[63:32], w);
		$display("test registers done");
		q = {8'h24, `CMD_INV, MFG, 8'h00};
		i_vcd.send(q, 0);
		expect_silent("inventory unarmed");
		foreach (acode[j]) begin
			send3(8'h00, acode[j], 0);
			expect_silent("arm not ready");
			@(posedge aclk) tag_ready <= 1;
			send3(8'h00, acode[j], 1);
			expect_silent("arm bad crc");
			send3({2'b00, 2'($urandom % 3 + 1), 4'h0}, acode[j], 0);
			expect_silent("arm selected");
			@(posedge aclk) tag_ready <= 0;
		end
		@(posedge aclk) tag_ready <= 1;
		axw(`REG_CTRL, 32'h0000_0000, r);
		send3(8'h00, `CMD_ARM, 0);
		expect_silent("arm disabled");
		axw(`REG_CTRL, `CTRL_RST, r);
		$display("test arm errors done");
		foreach (acode[j]) begin
			send3({6'h00, 2'($urandom)}, acode[j], 0);
			id_resp();
			expect_resp(acode[j] == `CMD_QARM, "arm");
		end
		axr(`REG_STATUS, w, r);
		chk_bit("latch set", 1, w[0]);
		$display("test arm done");
		q = {8'h24, `CMD_INV, MFG, 8'h00};
		i_vcd.send(q, 1);
		expect_silent("inventory bad crc");
		i_vcd.send(q, 0);
		id_resp();
		expect_resp(0, "inventory");
		@(posedge aclk) power_off <= 1;
		@(posedge aclk) power_off <= 0;
		axr(`REG_STATUS, w, r);
		chk_bit("latch after power off", 0, w[0]);
		i_vcd.send(q, 0);
		expect_silent("inventory after power off");
		send3(8'h00, `CMD_ARM, 0);
		id_resp();
		expect_resp(0, "rearm");
		// sixteen slots, empty mask: own slot is the low uid nibble
		q = {8'h04, `CMD_INV, MFG, 8'h00};
		i_vcd.send(q, 0);
		for (int s = 0; s < uid[3:0]; s++) begin
			expect_silent("empty slot");
			i_vcd.bare_eof();
		end
		id_resp();
		expect_resp(0, "slot reply");
		$display("test inventory done");
		burst(16'h07E0, 8'd31, 1);
		repeat (6) begin
			fb = 11'($urandom);
			burst({5'h0, fb}, 8'($urandom % (32 - fb[4:0])), 1'($urandom));
		end
		$display("test burst done");
		foreach (ecode[j]) begin
			q = {efl[j], `CMD_BURST, MFG, ef[j][7:0], ef[j][15:8], en[j]};
			i_vcd.send(q, ebad[j]);
			e = {`RESP_FAIL, ecode[j]};
			expect_resp(1, "burst error");
		end
		$display("test burst errors done");
		tally_and_finish();
	end
endmodule
